// *** hdl/cmp_instr_tick.sv ***
/*
 * instruction-cycle strobe: one pulse every CLKS clocks.
 * assumes a free-running aclk.
 */
`timescale 1ns/10ps
`default_nettype none

module cmp_instr_tick #(
	parameter int CLKS = 4
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// strobe
	output var  logic tick
);

	localparam int CW = $clog2(CLKS);
	localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

	logic [CW-1:0] count;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count <= '0;
		else if (count == LAST)
			count <= '0;
		else
			count <= count + CW'(1);
	end

	assign tick = (count == LAST);

endmodule : cmp_instr_tick

`default_nettype wire

// *** hdl/cmp_one_ctrl.sv ***
/*
 * first comparator: control register, result latch, pin gating and
 * change interrupt behind an AXI4-Lite slave.
 * assumes the analog array reports, for each {reference, channel}
 * choice, whether the non-inverting input exceeds the inverting one.
 */
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1: the comparator works only while control bit 7 is set.
// RULE2: bits 1:0 pick one of four pins for the inverting input.
// RULE3: bit 2 picks the internal reference (1) or the plus pin (0).
// RULE4: bit 6 is a read-only result flag that resets to 0.
// RULE5: the flag is 1 when plus exceeds minus, inverted by bit 4.
// RULE6: the flag is latched each instruction cycle; the pin is not.
// RULE7: the pin is driven only with output enable, enable, direction 0.
// RULE8: the interrupt works the same whatever the pin enable says.
// RULE9: bit 3 selects normal speed (1) or low power (0), reset 0.
// RULE10: writes touch only writable bits; all bits read 0 after reset.
module cmp_one_ctrl #(
	parameter int INSTR_CLKS = cmp_one_pkg::INSTR_CLKS
) (
	// clock and reset
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	// write address channel
	input  wire logic [cmp_one_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                           awvalid,
	output var  logic                           awready,
	// write data channel
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output var  logic                           wready,
	// write response channel
	output var  logic [1:0]                     bresp,
	output var  logic                           bvalid,
	input  wire logic                           bready,
	// read address channel
	input  wire logic [cmp_one_pkg::ADDR_W-1:0] araddr,
	input  wire logic                           arvalid,
	output var  logic                           arready,
	// read data channel
	output var  logic [31:0]                    rdata,
	output var  logic [1:0]                     rresp,
	output var  logic                           rvalid,
	input  wire logic                           rready,
	// analog core
	input  wire logic [7:0]                     plus_above_minus,
	output var  logic                           cmp_enable,
	output var  logic [1:0]                     cmp_channel_select,
	output var  logic                           cmp_reference_select,
	output var  logic                           cmp_speed_normal,
	// output pin
	input  wire logic                           port_a_direction,
	output var  logic                           cmp_pin_out,
	output var  logic                           cmp_pin_oe,
	// interrupt
	output var  logic                           irq
);
	import cmp_one_pkg::*;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a[1:0] == 2'h0)
		begin
			if (a[ADDR_W-1:2] == CTRL_IDX[ADDR_W-3:0])
				s = SEL_CTRL;
			else if (a[ADDR_W-1:2] == STAT_IDX[ADDR_W-3:0])
				s = SEL_STAT;
			else if (a[ADDR_W-1:2] == MASK_IDX[ADDR_W-3:0])
				s = SEL_MASK;
		end
		return s;
	endfunction : decode

	logic [7:0]      ctrl;
	logic            cmp_result;
	logic            result_prev;
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] mask;
	logic [EV_W-1:0] events;
	logic            tick;
	logic            raw_sel;
	logic            raw_sync;
	logic            aw_held;
	logic            w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]     w_data_q;
	logic [3:0]      w_strb_q;
	logic            do_write;
	logic            do_read;
	reg_sel_t        wr_sel;
	reg_sel_t        rd_sel;
	logic [7:0]      ctrl_view;

	// ---------------------------------------------------------------
	// analog steering
	// ---------------------------------------------------------------
	assign cmp_enable           = ctrl[ENABLE_BIT]; // RULE1
	assign cmp_channel_select   = ctrl[CHAN_HI:CHAN_LO]; // RULE2
	assign cmp_reference_select = ctrl[REFSEL_BIT]; // RULE3
	assign cmp_speed_normal     = ctrl[SPEED_BIT]; // RULE9

	// pick the decision of the selected input pair
	assign raw_sel = plus_above_minus[{ctrl[REFSEL_BIT],
		ctrl[CHAN_HI:CHAN_LO]}]; // RULE2 RULE3

	// ---------------------------------------------------------------
	// pin path
	// ---------------------------------------------------------------
	// unlatched on purpose: the pin follows the comparator directly
	assign cmp_pin_out = ctrl[ENABLE_BIT] &
		(raw_sel ^ ctrl[INVERT_BIT]); // RULE6 RULE5
	assign cmp_pin_oe  = ctrl[PIN_OE_BIT] & ctrl[ENABLE_BIT] &
		~port_a_direction; // RULE7

	// ---------------------------------------------------------------
	// result latch
	// ---------------------------------------------------------------
	cmp_sync3 u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (raw_sel),
		.sync_out (raw_sync)
	);

	cmp_instr_tick #(
		.CLKS (INSTR_CLKS)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	// disabled comparator reads as 0 whatever the polarity
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cmp_result <= 1'b0; // RULE4
		else if (tick)
			cmp_result <= ctrl[ENABLE_BIT] &
				(raw_sync ^ ctrl[INVERT_BIT]); // RULE6 RULE5 RULE1
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			result_prev <= 1'b0;
		else
			result_prev <= cmp_result;
	end

	// ---------------------------------------------------------------
	// interrupt
	// ---------------------------------------------------------------
	// sourced from the latched flag, never from the pin gating
	always_comb
	begin
		events            = '0;
		events[EV_CHANGE] = cmp_result ^ result_prev; // RULE8
		events[EV_RISE]   = cmp_result & ~result_prev;
		events[EV_FALL]   = ~cmp_result & result_prev;
	end

	// a new event in the clearing read cycle is kept
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status <= EV_RESET;
		else if (do_read && rd_sel == SEL_STAT)
			status <= events;
		else
			status <= status | events;
	end

	assign irq = |(status & mask); // RULE8

	// ---------------------------------------------------------------
	// write channel
	// ---------------------------------------------------------------
	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_sel   = decode(aw_addr_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			aw_held <= 1'b0;
		else if (awvalid && awready)
			aw_held <= 1'b1;
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			w_held <= 1'b0;
		else if (wvalid && wready)
			w_held <= 1'b1;
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end
		else
		begin
			if (awvalid && awready)
				aw_addr_q <= awaddr;
			if (wvalid && wready)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// only byte lane 0 carries data; the result bit is never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl <= CTRL_RESET; // RULE10 RULE9
		else if (do_write && wr_sel == SEL_CTRL && w_strb_q[0])
			ctrl <= w_data_q[7:0] & CTRL_WMASK; // RULE10
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mask <= EV_RESET;
		else if (do_write && wr_sel == SEL_MASK && w_strb_q[0])
			mask <= w_data_q[EV_W-1:0];
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	assign arready = !rvalid;
	assign do_read = arvalid && arready;
	assign rd_sel  = decode(araddr);

	always_comb
	begin
		ctrl_view             = ctrl;
		ctrl_view[RESULT_BIT] = cmp_result; // RULE4
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end
		else if (do_read)
		begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			unique case (rd_sel)
				SEL_CTRL: rdata <= {24'h000000, ctrl_view};
				SEL_STAT: rdata <= {29'h00000000, status};
				SEL_MASK: rdata <= {29'h00000000, mask};
				SEL_NONE:
				begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_enable_gate: assert property ( // RULE1
		tick && !ctrl[ENABLE_BIT] |=> !cmp_result)
		else $error("result set while comparator disabled");

	a_input_route: assert property ( // RULE2
		cmp_enable |-> cmp_pin_out == (plus_above_minus[{
		cmp_reference_select, cmp_channel_select}] ^ ctrl[INVERT_BIT]))
		else $error("pin does not follow selected input");

	a_ref_select: assert property ( // RULE3
		do_write && wr_sel == SEL_CTRL && w_strb_q[0] |=>
		cmp_reference_select == $past(w_data_q[REFSEL_BIT]))
		else $error("reference select not written");

	a_flag_readonly: assert property ( // RULE4
		$changed(cmp_result) |-> $past(tick))
		else $error("result flag changed outside a latch edge");

	a_flag_polarity: assert property ( // RULE5
		tick && ctrl[ENABLE_BIT] |=>
		cmp_result == ($past(raw_sync) ^ $past(ctrl[INVERT_BIT])))
		else $error("result flag polarity wrong");

	a_latch_period: assert property ( // RULE6
		tick |=> !tick [*3] ##1 tick)
		else $error("latch strobe not every instruction cycle");

	a_pin_gating: assert property ( // RULE7
		cmp_pin_oe |-> ctrl[PIN_OE_BIT] && cmp_enable &&
		!port_a_direction)
		else $error("pin driven without all enables");

	a_irq_change: assert property ( // RULE8
		$changed(cmp_result) |=> status[EV_CHANGE])
		else $error("change event not recorded");

	a_speed_bit: assert property ( // RULE9
		!$past(aresetn) |-> !cmp_speed_normal && ctrl == CTRL_RESET
		&& !cmp_result)
		else $error("control not zero after reset");

	a_write_mask: assert property ( // RULE10
		do_write && wr_sel == SEL_CTRL && w_strb_q[0] |=>
		ctrl == ($past(w_data_q[7:0]) & CTRL_WMASK))
		else $error("control write stored wrong bits");

	c_pin_driven: cover property (cmp_pin_oe && cmp_pin_out);
	c_irq_raised: cover property (irq);
	c_ctrl_write: cover property (do_write && wr_sel == SEL_CTRL);
	c_stat_read:  cover property (do_read && rd_sel == SEL_STAT);

endmodule : cmp_one_ctrl

`default_nettype wire

// *** hdl/cmp_sync3.sv ***
/*
 * three-stage synchroniser with an agreement filter.
 * assumes the input is asynchronous to aclk.
 */
`timescale 1ns/10ps
`default_nettype none

module cmp_sync3 (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// data
	input  wire logic async_in,
	output var  logic sync_out
);

	logic stage1;
	logic stage2;
	logic stage3;

	// first stage feeds only the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end
		else
		begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_out <= 1'b0;
		else if (stage2 == stage3)
			sync_out <= stage3;
	end

endmodule : cmp_sync3

`default_nettype wire

// *** inc/cmp_one_pkg.sv ***
/*
 * constants for the first comparator control block: register indices,
 * field positions, reset values, bus responses and timing counts.
 * assumes a 32-bit AXI4-Lite bus, one register per aligned word.
 */
`default_nettype none

package cmp_one_pkg;

	// ---------------------------------------------------------------
	// register map (index, byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int          ADDR_W    = 12;
	localparam logic [11:0] CTRL_IDX  = 12'h119;
	localparam logic [11:0] STAT_IDX  = 12'h120;
	localparam logic [11:0] MASK_IDX  = 12'h121;

	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	localparam int         ENABLE_BIT = 7;
	localparam int         RESULT_BIT = 6;
	localparam int         PIN_OE_BIT = 5;
	localparam int         INVERT_BIT = 4;
	localparam int         SPEED_BIT  = 3;
	localparam int         REFSEL_BIT = 2;
	localparam int         CHAN_HI    = 1;
	localparam int         CHAN_LO    = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hbf;

	// ---------------------------------------------------------------
	// status and mask fields
	// ---------------------------------------------------------------
	localparam int         EV_W       = 3;
	localparam int         EV_CHANGE  = 0;
	localparam int         EV_RISE    = 1;
	localparam int         EV_FALL    = 2;
	localparam logic [2:0] EV_RESET   = 3'h0;

	// ---------------------------------------------------------------
	// bus responses
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 50;
	localparam int INSTR_CYCLE_NS = 200;
	localparam int INSTR_CLKS     = INSTR_CYCLE_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		SEL_CTRL = 2'h0,
		SEL_STAT = 2'h1,
		SEL_MASK = 2'h3,
		SEL_NONE = 2'h2
	} reg_sel_t;

endpackage : cmp_one_pkg

`default_nettype wire

// *** verification/cmp_one_ctrl_tb.sv ***
/*
 * self-checking bench for the first comparator control block.
 * assumes cmp_one_pkg is compiled first and the design keeps its
 * assertions inside its own files.
 */
`timescale 1ns/10ps
`default_nettype none

module cmp_one_ctrl_tb;
	import cmp_one_pkg::*;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam logic [11:0] CTRL_A = CTRL_IDX << 2;
	localparam logic [11:0] STAT_A = STAT_IDX << 2;
	localparam logic [11:0] MASK_A = MASK_IDX << 2;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  plus_above_minus;
	logic        cmp_enable, cmp_reference_select, cmp_speed_normal;
	logic [1:0]  cmp_channel_select;
	logic        port_a_direction, cmp_pin_out, cmp_pin_oe, irq;
	int          bad_count, total_checks, cycles;
	logic [31:0] rd_v;
	logic [1:0]  rsp;

	cmp_one_ctrl cmp_one_ctrl_i (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.plus_above_minus(plus_above_minus), .cmp_enable(cmp_enable),
		.cmp_channel_select(cmp_channel_select),
		.cmp_reference_select(cmp_reference_select),
		.cmp_speed_normal(cmp_speed_normal),
		.port_a_direction(port_a_direction), .cmp_pin_out(cmp_pin_out),
		.cmp_pin_oe(cmp_pin_oe), .irq(irq));

	// ---------------------------------------------------------------
	// clock and hang guard
	// ---------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// whole run needs well under 3000 cycles
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			bad_count++;
			final_report();
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// readies do not depend on inputs, so sampling at the falling edge
	// tells whether the next rising edge completes the handshake
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_hs, w_hs, b_hs;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs)
		begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs  = wvalid && wready;
			b_hs  = bvalid;
			r     = bresp;
			@(posedge aclk);
			if (aw_hs)
				awvalid <= 1'b0;
			if (w_hs)
				wvalid <= 1'b0;
		end
		// bready stays high: a next call would otherwise drive it twice
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_hs, r_hs;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs)
		begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs  = rvalid;
			d     = rdata;
			r     = rresp;
			@(posedge aclk);
			if (ar_hs)
				arvalid <= 1'b0;
		end
		// rready stays high for the same reason as bready
	endtask : axi_read

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		axi_write(a, {24'h0, d}, 4'hf, rsp);
		chk(rsp, RESP_OKAY);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] exp_r);
		axi_read(a, rd_v, rsp);
		chk(rd_v, exp);
		chk(rsp, exp_r);
	endtask : rd_chk

	// sync stages plus one instruction cycle, with margin
	task automatic settle();
		repeat (12) @(posedge aclk);
	endtask : settle

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial
	begin
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 12'h0;
		araddr = 12'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		plus_above_minus = 8'h00;
		port_a_direction = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(CTRL_A, 32'h0, RESP_OKAY);
		rd_chk(STAT_A, 32'h0, RESP_OKAY);
		rd_chk(MASK_A, 32'h0, RESP_OKAY);
		chk({cmp_pin_oe, cmp_pin_out, irq, cmp_speed_normal}, 4'h0);
		$display("test reset done");

		// disabled: result and pin held low even when inverted
		wr(CTRL_A, 8'h7f);
		settle();
		rd_chk(CTRL_A, 32'h3f, RESP_OKAY);
		chk({cmp_enable, cmp_speed_normal}, 2'b01);
		chk({cmp_pin_out, cmp_pin_oe}, 2'b00);
		wr(CTRL_A, 8'hc0);
		settle();
		rd_chk(CTRL_A, 32'h80, RESP_OKAY);
		chk({cmp_enable, cmp_speed_normal}, 2'b10);
		axi_write(CTRL_A, 32'hff, 4'h0, rsp);
		chk(rsp, RESP_OKAY);
		rd_chk(CTRL_A, 32'h80, RESP_OKAY);
		$display("test control bits done");

		// every reference and channel code, plain and inverted
		for (int sel = 0; sel < 8; sel++)
		begin
			plus_above_minus <= 8'h01 << sel;
			wr(CTRL_A, 8'h80 | 8'(sel));
			chk({cmp_reference_select, cmp_channel_select}, sel);
			chk(cmp_pin_out, 1'b1);
			settle();
			rd_chk(CTRL_A, 32'hc0 | sel, RESP_OKAY);
			plus_above_minus <= ~(8'h01 << sel);
			settle();
			rd_chk(CTRL_A, 32'h80 | sel, RESP_OKAY);
			wr(CTRL_A, 8'h90 | 8'(sel));
			settle();
			rd_chk(CTRL_A, 32'hd0 | sel, RESP_OKAY);
		end
		// pin follows the raw input before any latch can act
		plus_above_minus <= 8'hff;
		@(negedge aclk);
		chk(cmp_pin_out, 1'b0);
		@(posedge aclk);
		$display("test routing done");

		// pin drive needs output enable, enable and direction 0
		for (int k = 0; k < 8; k++)
		begin
			port_a_direction <= k[2];
			wr(CTRL_A, {k[1], 1'b0, k[0], 5'h0});
			@(negedge aclk);
			chk(cmp_pin_oe, k[0] & k[1] & ~k[2]);
			@(posedge aclk);
		end
		$display("test pin gating done");

		// interrupt behaves alike with the pin enable bit on or off (direction stays 1, so the pin is never driven)
		wr(MASK_A, 8'h07);
		for (int oe = 0; oe < 2; oe++)
		begin
			plus_above_minus <= 8'h00;
			wr(CTRL_A, 8'h80 | (8'(oe) << PIN_OE_BIT));
			settle();
			axi_read(STAT_A, rd_v, rsp);
			chk(irq, 1'b0);
			plus_above_minus <= 8'h01;
			settle();
			chk(irq, 1'b1);
			rd_chk(STAT_A, 32'h3, RESP_OKAY);
			chk(irq, 1'b0);
		end
		wr(MASK_A, 8'h00);
		plus_above_minus <= 8'h00;
		settle();
		chk(irq, 1'b0);
		rd_chk(STAT_A, 32'h5, RESP_OKAY);
		rd_chk(STAT_A, 32'h0, RESP_OKAY);
		$display("test interrupt done");

		// unmapped place answers with an error and no data
		axi_write(12'h000, 32'hff, 4'hf, rsp);
		chk(rsp, RESP_SLVERR);
		rd_chk(12'h000, 32'h0, RESP_SLVERR);
		rd_chk(MASK_A, 32'h0, RESP_OKAY);
		$display("test unmapped done");
		final_report();
	end

endmodule : cmp_one_ctrl_tb

`default_nettype wire
